//--- upr_ctrl.sv
// Two-channel transmit pin, space indication and low-power control
// Function
// - Transmit pin high in reset, idle, disabled
// - Loopback disables pin, routes stream to receiver
// - Space indication low when FIFO has room (block DMA) or is empty (single DMA)
// - Block DMA: indication high when FIFO full
// - Indication also paces single-character DMA writes
// - Sleep input enters low power once its last two synchroniser stages agree
// - Sleep stops oscillator, isolates host pins
// - Only sleep deassertion leaves low power
// - Sleep falling edge clears FIFOs, transmit state, line and indication
// - Bus select high means separate strobes
// - Bus select low means strobe plus direction
// - Reset polarity follows bus select
`timescale 1ns/1ns
`include "upr_params.svh"
module upr_ctrl (
    input  wire logic       CLK_SYS_I,
    input  wire logic       RESET_I,
    input  wire logic       MASTER_RESET_PIN_I,
    input  wire logic       BUS_SELECT_I,
    input  wire logic       SLEEP_REQUEST_IN_I,
    input  wire logic       OSC_CLOCK_IN_I,
    input  wire logic       CS_N_I,
    input  wire logic       CHAN_SEL_I,
    input  wire logic       RD_STROBE_I,
    input  wire logic       WR_STROBE_I,
    input  wire logic [7:0] WR_DATA_I,
    input  wire logic [1:0] TX_ENABLE_I,
    input  wire logic [1:0] LOOPBACK_I,
    input  wire logic [1:0] DMA_MODE_I,
    output logic            SERIAL_OUT_CHAN_A_O,
    output logic            SERIAL_OUT_CHAN_B_O,
    output logic            XMIT_SPACE_AVAIL_N_CHAN_A_O,
    output logic            XMIT_SPACE_AVAIL_N_CHAN_B_O,
    output logic [1:0]      LOOP_RX_O,
    output logic            OSC_CLOCK_OUT_O,
    output logic            HOST_ISOLATED_O,
    output logic [1:0]      WR_ACCEPT_O
);
    // ------------------------------------------------------------
    // Pin synchronisers (three stages, second and third agree)
    // ------------------------------------------------------------
    logic [2:0] slp_sy_reg, slp_sy_next;    // Sleep request stages
    logic [2:0] bs_sy_reg,  bs_sy_next;     // Bus select stages
    logic [2:0] mr_sy_reg,  mr_sy_next;     // Master reset stages
    logic [2:0] rd_sy_reg,  rd_sy_next;     // Read/direction stages
    logic [2:0] wr_sy_reg,  wr_sy_next;     // Write strobe stages
    logic [2:0] cs_sy_reg,  cs_sy_next;     // Chip select stages
    logic       slp_reg, slp_next;          // Filtered sleep level
    logic       bs_reg,  bs_next;           // Filtered bus select
    logic       mr_reg,  mr_next;           // Filtered master reset pin
    logic       wr_q_reg, wr_q_next;        // Previous write qualifier

    // Shift every pin one stage, update filtered level when agreed
    always_comb begin
        slp_sy_next = {slp_sy_reg[1:0], SLEEP_REQUEST_IN_I};
        bs_sy_next  = {bs_sy_reg[1:0],  BUS_SELECT_I};
        mr_sy_next  = {mr_sy_reg[1:0],  MASTER_RESET_PIN_I};
        rd_sy_next  = {rd_sy_reg[1:0],  RD_STROBE_I};
        wr_sy_next  = {wr_sy_reg[1:0],  WR_STROBE_I};
        cs_sy_next  = {cs_sy_reg[1:0],  CS_N_I};
        slp_next    = (slp_sy_reg[1] == slp_sy_reg[2]) ? slp_sy_reg[2] : slp_reg;
        bs_next     = (bs_sy_reg[1] == bs_sy_reg[2]) ? bs_sy_reg[2] : bs_reg;
        mr_next     = (mr_sy_reg[1] == mr_sy_reg[2]) ? mr_sy_reg[2] : mr_reg;
    end

    // ------------------------------------------------------------
    // Host access decode
    // ------------------------------------------------------------
    logic host_wr;                           // Write qualifier level
    logic wr_pulse;                          // One write per strobe
    logic pin_reset;                         // Master reset, polarity applied
    logic sleep_exit;                        // Sleep falling edge
    logic soft_clear;                        // Synchronous full clear
    logic cs_low;                            // Chip select low in both late stages
    logic wr_low;                            // Write strobe low in both late stages
    logic dir_low;                           // Direction pin low in both late stages

    // A pin level counts only once the last two stages agree
    assign cs_low  = !cs_sy_reg[1] && !cs_sy_reg[2];
    assign wr_low  = !wr_sy_reg[1] && !wr_sy_reg[2];
    assign dir_low = !rd_sy_reg[1] && !rd_sy_reg[2];

    always_comb begin
        host_wr = 1'b0;
        if (bs_reg) begin
            host_wr = cs_low && wr_low;
        end else begin
            host_wr = cs_low && wr_low && dir_low;
        end
        wr_q_next = host_wr;
    end
    // Active high with select high, active low otherwise
    assign pin_reset  = bs_reg ? mr_reg : !mr_reg;
    assign sleep_exit = slp_reg && (slp_sy_reg[1] == slp_sy_reg[2]) && !slp_sy_reg[2];
    assign soft_clear = pin_reset || sleep_exit;
    // Host ignored while asleep; only the sleep pin brings it back
    assign wr_pulse   = host_wr && !wr_q_reg && !slp_reg;

    always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
        if (RESET_I) begin
            slp_sy_reg <= 3'h0;
            bs_sy_reg  <= 3'h7;
            mr_sy_reg  <= 3'h0;
            rd_sy_reg  <= 3'h7;
            wr_sy_reg  <= 3'h7;
            cs_sy_reg  <= 3'h7;
            slp_reg    <= 1'b0;
            bs_reg     <= 1'b1;
            mr_reg     <= 1'b0;
            wr_q_reg   <= 1'b0;
        end else begin
            slp_sy_reg <= slp_sy_next;
            bs_sy_reg  <= bs_sy_next;
            mr_sy_reg  <= mr_sy_next;
            rd_sy_reg  <= rd_sy_next;
            wr_sy_reg  <= wr_sy_next;
            cs_sy_reg  <= cs_sy_next;
            slp_reg    <= slp_next;
            bs_reg     <= bs_next;
            mr_reg     <= mr_next;
            wr_q_reg   <= wr_q_next;
        end
    end

    // ------------------------------------------------------------
    // Oscillator gate and host isolation
    // ------------------------------------------------------------
    assign OSC_CLOCK_OUT_O = OSC_CLOCK_IN_I && !slp_reg;
    assign HOST_ISOLATED_O = slp_reg;

    // ------------------------------------------------------------
    // Per-channel transmit path
    // ------------------------------------------------------------
    logic [1:0] ser;                         // Serial stream per channel
    logic [1:0] space_n;                     // Space indication per channel

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic       f_in_valid, f_in_ready, f_out_valid, f_out_ready;
        logic [7:0] f_out_data;
        logic [9:0] sh_reg,  sh_next;        // Frame shifter
        logic [3:0] bit_reg, bit_next;       // Bits left
        logic [15:0] div_reg, div_next;      // Baud divider
        logic       line_reg, line_next;     // Registered line level
        logic       sp_reg,  sp_next;        // Registered space indication
        upr_pkg::upr_tx_state_type st_reg, st_next;
        logic       tick;

        // A clear in the same cycle wins over a write
        assign f_in_valid  = wr_pulse && (CHAN_SEL_I == 1'(c)) && !soft_clear;
        assign f_out_ready = (st_reg == upr_pkg::UPR_TX_IDLE) && TX_ENABLE_I[c] && !slp_reg;
        assign tick        = (div_reg == 16'h0000);

        upr_fifo u_fifo (
            .clk_i       (CLK_SYS_I),
            .rst_i       (RESET_I),
            .flush_i     (soft_clear),
            .in_valid_i  (f_in_valid),
            .in_ready_o  (f_in_ready),
            .in_data_i   (WR_DATA_I),
            .out_valid_o (f_out_valid),
            .out_ready_i (f_out_ready),
            .out_data_o  (f_out_data)
        );

        // Shifter, divider and indication next values
        always_comb begin
            st_next   = st_reg;
            sh_next   = sh_reg;
            bit_next  = bit_reg;
            div_next  = tick ? `UPR_BAUD_DIV - 16'h0001 : div_reg - 16'h0001;
            line_next = `UPR_LINE_IDLE;
            sp_next   = `UPR_SPACE_ACTIVE;
            case (st_reg)
                upr_pkg::UPR_TX_IDLE: begin
                    if (f_out_valid && f_out_ready) begin
                        sh_next  = {1'b1, f_out_data, 1'b0};
                        bit_next = `UPR_FRAME_BITS;
                        div_next = `UPR_BAUD_DIV - 16'h0001;
                        st_next  = upr_pkg::UPR_TX_SHIFT;
                    end
                end
                upr_pkg::UPR_TX_SHIFT: begin
                    line_next = sh_reg[0];
                    if (tick) begin
                        sh_next  = {1'b1, sh_reg[9:1]};
                        bit_next = bit_reg - 4'h1;
                        if (bit_reg == 4'h1) st_next = upr_pkg::UPR_TX_IDLE;
                    end
                end
                default: st_next = upr_pkg::UPR_TX_IDLE;
            endcase
            if (!TX_ENABLE_I[c]) line_next = `UPR_LINE_IDLE;
            // Block mode drops indication on full; single mode on any pending word
            if (DMA_MODE_I[c] == upr_pkg::UPR_DMA_BLOCK) begin
                sp_next = f_in_ready ? `UPR_SPACE_ACTIVE : `UPR_SPACE_IDLE;
            end else begin
                sp_next = (f_in_ready && !f_out_valid) ? `UPR_SPACE_ACTIVE
                                                       : `UPR_SPACE_IDLE;
            end
            if (soft_clear) begin
                st_next   = upr_pkg::UPR_TX_IDLE;
                line_next = `UPR_LINE_IDLE;
                sp_next   = `UPR_SPACE_ACTIVE;
            end
        end

        always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
            if (RESET_I) begin
                st_reg   <= upr_pkg::UPR_TX_IDLE;
                sh_reg   <= 10'h3ff;
                bit_reg  <= 4'h0;
                div_reg  <= 16'h0000;
                line_reg <= `UPR_LINE_IDLE;
                sp_reg   <= `UPR_SPACE_ACTIVE;
            end else begin
                st_reg   <= st_next;
                sh_reg   <= sh_next;
                bit_reg  <= bit_next;
                div_reg  <= div_next;
                line_reg <= line_next;
                sp_reg   <= sp_next;
            end
        end

        assign ser[c]         = line_reg;
        assign space_n[c]     = sp_reg;
        assign WR_ACCEPT_O[c] = f_in_valid && f_in_ready;
    end

    // ------------------------------------------------------------
    // Pin outputs with loopback gating
    // ------------------------------------------------------------
    assign SERIAL_OUT_CHAN_A_O = LOOPBACK_I[0] ? `UPR_LINE_IDLE : ser[0];
    assign SERIAL_OUT_CHAN_B_O = LOOPBACK_I[1] ? `UPR_LINE_IDLE : ser[1];
    assign LOOP_RX_O           = {LOOPBACK_I[1] ? ser[1] : `UPR_LINE_IDLE,
                                  LOOPBACK_I[0] ? ser[0] : `UPR_LINE_IDLE};
    assign XMIT_SPACE_AVAIL_N_CHAN_A_O = space_n[0];
    assign XMIT_SPACE_AVAIL_N_CHAN_B_O = space_n[1];
endmodule : upr_ctrl

// ------------------------------------------------------------
// Transmit FIFO: flip-flop storage, valid and ready on both sides
// ------------------------------------------------------------
module upr_fifo #(
    parameter int WIDTH = `UPR_FIFO_WIDTH,
    parameter int DEPTH = `UPR_FIFO_DEPTH,
    parameter int AW    = `UPR_FIFO_AW
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];      // Storage words
    logic [AW-1:0]    wr_reg, wr_next;      // Write index
    logic [AW-1:0]    rd_reg, rd_next;      // Read index
    logic [AW:0]      cnt_reg, cnt_next;    // Fill count
    logic             push, pop;

    // Room while the count is below the depth
    assign in_ready_o  = (cnt_reg < (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rd_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Next pointers and count
    always_comb begin
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (flush_i) begin
            wr_next  = '0;
            rd_next  = '0;
            cnt_next = '0;
        end else begin
            if (push) wr_next = wr_reg + 1'b1;
            if (pop)  rd_next = rd_reg + 1'b1;
            if (push && !pop) cnt_next = cnt_reg + 1'b1;
            else if (pop && !push) cnt_next = cnt_reg - 1'b1;
        end
    end

    // Register pointers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_i) begin
        if (push && !flush_i) mem_reg[wr_reg] <= in_data_i;
    end
endmodule : upr_fifo

//--- upr_params.svh
// Constants for the pin-level transmit and low-power control block
`ifndef UPR_PARAMS_SVH
`define UPR_PARAMS_SVH
`define UPR_FIFO_WIDTH     8
`define UPR_FIFO_DEPTH     8
`define UPR_FIFO_AW        3
`define UPR_LINE_IDLE      1'b1
`define UPR_SPACE_ACTIVE   1'b0
`define UPR_SPACE_IDLE     1'b1
`define UPR_BAUD_DIV       16'h0010
`define UPR_FRAME_BITS     4'ha
`endif

//--- upr_pkg.sv
// Types shared by the pin-level control block
package upr_pkg;
    typedef enum logic [1:0] {
        UPR_TX_IDLE,
        UPR_TX_SHIFT
    } upr_tx_state_type;
    typedef enum logic {
        UPR_DMA_SINGLE,
        UPR_DMA_BLOCK
    } upr_dma_mode_type;
endpackage : upr_pkg

//--- upr_fifo.sv
// Kept empty: the transmit FIFO module sits beside the control logic

//--- upr_ctrl_chk.sv
// Assertions on the pin-level transmit and low-power control ports
`timescale 1ns/1ns
module upr_ctrl_chk (
    input wire logic       CLK_SYS_I,
    input wire logic       RESET_I,
    input wire logic       SLEEP_REQUEST_IN_I,
    input wire logic [1:0] TX_ENABLE_I,
    input wire logic [1:0] LOOPBACK_I,
    input wire logic [1:0] DMA_MODE_I,
    input wire logic       SERIAL_OUT_CHAN_A_O,
    input wire logic       SERIAL_OUT_CHAN_B_O,
    input wire logic       XMIT_SPACE_AVAIL_N_CHAN_A_O,
    input wire logic       XMIT_SPACE_AVAIL_N_CHAN_B_O,
    input wire logic [1:0] LOOP_RX_O,
    input wire logic       OSC_CLOCK_OUT_O,
    input wire logic       HOST_ISOLATED_O,
    input wire logic [1:0] WR_ACCEPT_O
);
    // Sampled on the system clock, quiet during reset
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);
    // Steps of sleep, wake and single-transfer pacing
    sequence asleep_s; HOST_ISOLATED_O [*4]; endsequence
    sequence woke_s; $fell(HOST_ISOLATED_O); endsequence
    sequence free_s; !XMIT_SPACE_AVAIL_N_CHAN_A_O && !XMIT_SPACE_AVAIL_N_CHAN_B_O; endsequence
    sequence pend_a_s; ##[1:4] XMIT_SPACE_AVAIL_N_CHAN_A_O; endsequence
    tx_off_high_a: assert property (!TX_ENABLE_I[1] [*2] |-> SERIAL_OUT_CHAN_B_O)
        else $error("line B low while disabled");
    loop_pin_high_a: assert property (LOOPBACK_I[0] |-> SERIAL_OUT_CHAN_A_O)
        else $error("line A driven in loopback");
    loop_rx_idle_a: assert property (!LOOPBACK_I[1] |-> LOOP_RX_O[1])
        else $error("loop stream B active outside loopback");
    sleep_enter_a: assert property ($rose(SLEEP_REQUEST_IN_I) |-> ##[1:6] HOST_ISOLATED_O)
        else $error("sleep not entered in time");
    osc_stop_a: assert property (HOST_ISOLATED_O [*2] |-> !OSC_CLOCK_OUT_O)
        else $error("oscillator runs in sleep");
    sleep_refuse_a: assert property (asleep_s |-> WR_ACCEPT_O == 2'b00)
        else $error("write taken in sleep");
    wake_space_a: assert property (woke_s |-> ##[0:6] free_s)
        else $error("space not free after wake");
    single_pace_a: assert property (WR_ACCEPT_O[0] && !DMA_MODE_I[0] |-> pend_a_s)
        else $error("pending word not shown on space A");
endmodule : upr_ctrl_chk
bind upr_ctrl upr_ctrl_chk chk (.*);

//--- upr_host_model.sv
// Host bus model issuing one write per strobe in either bus style
`timescale 1ns/1ns
module upr_host_model (
    input  wire logic       clk_i,
    input  wire logic       style_i,
    input  wire logic [1:0] accept_i,
    output logic            cs_n_o = 1'b1,
    output logic            chan_o = 1'b0,
    output logic            rd_o   = 1'b1,
    output logic            wr_o   = 1'b1,
    output logic [7:0]      data_o = 8'h00
);
    // Hold the strobe until taken or for eight cycles, then rest three cycles
    task automatic write(input logic ch, input logic [7:0] d, output logic hit);
        hit = 1'b0;
        cs_n_o <= 1'b0;
        chan_o <= ch;
        data_o <= d;
        wr_o   <= 1'b0;
        rd_o   <= style_i;
        for (int n = 0; n < 8 && !hit; n++) begin
            @(posedge clk_i);
            hit = accept_i[ch];
        end
        cs_n_o <= 1'b1;
        wr_o   <= 1'b1;
        rd_o   <= 1'b1;
        data_o <= ~d;         // Released data never keeps its value
        repeat (3) @(posedge clk_i);
    endtask : write
endmodule : upr_host_model

//--- tb_top.sv
// Self-checking bench for the pin-level transmit and low-power control
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic       clk = 1'b0, rst = 1'b1, mrst = 1'b0, bsel = 1'b1, slp = 1'b0, osc = 1'b0;
    logic [1:0] txen = 2'b00, lpb = 2'b00, dma = 2'b00, acc, lrx;
    logic       cs_n, chs, rd, wr, ser_a, ser_b, sp_a, sp_b, osc_o, iso, hit, rx_a;
    logic [7:0] wd, d, got;
    int         miscompares = 0, num_checks = 0, lows, want, seed;
    int         exp_a[$];    // Bytes expected on channel A
    // Clock, oscillator stand-in, receive tap of channel A
    initial forever #50 clk = ~clk;
    always @(posedge clk) osc <= ~osc;
    assign rx_a = lpb[0] ? lrx[0] : ser_a;
    upr_host_model host (.clk_i(clk), .style_i(bsel), .accept_i(acc), .cs_n_o(cs_n),
        .chan_o(chs), .rd_o(rd), .wr_o(wr), .data_o(wd));
    upr_ctrl uut (.CLK_SYS_I(clk), .RESET_I(rst), .MASTER_RESET_PIN_I(mrst), .BUS_SELECT_I(bsel),
        .SLEEP_REQUEST_IN_I(slp), .OSC_CLOCK_IN_I(osc), .CS_N_I(cs_n), .CHAN_SEL_I(chs),
        .RD_STROBE_I(rd), .WR_STROBE_I(wr), .WR_DATA_I(wd), .TX_ENABLE_I(txen), .LOOPBACK_I(lpb),
        .DMA_MODE_I(dma), .SERIAL_OUT_CHAN_A_O(ser_a), .SERIAL_OUT_CHAN_B_O(ser_b),
        .XMIT_SPACE_AVAIL_N_CHAN_A_O(sp_a), .XMIT_SPACE_AVAIL_N_CHAN_B_O(sp_b), .LOOP_RX_O(lrx),
        .OSC_CLOCK_OUT_O(osc_o), .HOST_ISOLATED_O(iso), .WR_ACCEPT_O(acc));
    // Random write; a byte taken on channel A joins the model queue
    task automatic put(input logic ch);
        d = 8'($urandom);
        host.write(ch, d, hit);
        if (hit === 1'b1 && ch == 1'b0) exp_a.push_back(d);
    endtask : put
    task automatic stop_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Frame decoder: mid-bit sampling, LSB first, against the queue
    initial begin : mon_a
        forever begin
            @(negedge rx_a);
            repeat (8) @(posedge clk);
            for (int b = 0; b < 8; b++) repeat (16) @(posedge clk) got[b] = rx_a;
            repeat (16) @(posedge clk);
            `CHK(exp_a.size() > 0, 1'b1)
            want = (exp_a.size() > 0) ? exp_a.pop_front() : 'h100;
            `CHK({rx_a, got}, {1'b1, want[7:0]})
        end
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
    // Main sequence
    initial begin
        seed = $urandom(54);
        repeat (8) @(posedge clk);
        `CHK({ser_a, ser_b, sp_a, sp_b}, 4'b1100)
        {rst, txen, dma} <= {1'b0, 2'b01, 2'b10};
        repeat (2) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            put(1'b0);
            `CHK(hit, 1'b1)
        end
        repeat (600) @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            put(1'b1);
            `CHK({hit, sp_b}, {1'(i < 8), 1'(i > 6)})
        end
        slp <= 1'b1;
        repeat (8) @(posedge clk);
        put(1'b0);
        `CHK({hit, iso, osc_o}, 3'b010)
        slp <= 1'b0;
        repeat (8) @(posedge clk);
        `CHK({iso, sp_b}, 2'b00)
        `CHK(osc_o, osc)
        txen <= 2'b11;
        lows = 0;
        repeat (200) @(posedge clk) lows += (ser_b !== 1'b1);
        `CHK(lows, 0)
        {bsel, mrst, lpb, txen, dma} <= {1'b0, 1'b1, 2'b01, 2'b01, 2'b00};
        repeat (8) @(posedge clk);
        put(1'b0);
        `CHK(hit, 1'b1)
        put(1'b1);
        `CHK({hit, sp_b}, 2'b11)
        repeat (300) @(posedge clk);
        mrst <= 1'b0;
        repeat (6) @(posedge clk);
        mrst <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK({exp_a.size() == 0, sp_b}, 2'b10)
        stop_test();
    end
endmodule : tb_top
